/* core/port_pins_pkg.sv */
// Constants for one packet port pin block.
// Assumes an APB master on pclk and pins sampled from outside the domain.
package port_pins_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_TX_DATA = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RX_DATA = 8'h14;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int CTRL_W = 4;
    localparam int CTRL_PHY_BIT = 2;
    localparam int CTRL_HDX_BIT = 3;
    localparam int IRQ_W = 7;
    localparam int IRQ_FRAME = 0, IRQ_RXERR = 1, IRQ_FALSE = 2, IRQ_COL = 3;
    localparam int IRQ_TXDONE = 4, IRQ_UNDER = 5, IRQ_OVER = 6;
    localparam int CODE_W = 10;
    localparam int LANES_W = 8;
    localparam int WORD_FLAG_BIT = 16;
    localparam logic [LANES_W-1:0] FALSE_CARRIER = 8'h0e;
    localparam logic [LANES_W-1:0] MASK_MII = 8'h0f, MASK_RMII = 8'h03, MASK_WIDE = 8'hff;
    localparam logic [3:0] WIDTH_MII = 4'h4, WIDTH_RMII = 4'h2, WIDTH_GMII = 4'h8;
    localparam logic [3:0] WIDTH_TBI = 4'ha;
    localparam logic [2:0] BEATS_MII = 3'h2, BEATS_RMII = 3'h4, BEATS_WIDE = 3'h1;
    localparam int SI_RXCLK = 0, SI_REF = 1, SI_BCA = 2, SI_BCB = 3, SI_TXCLK = 4;
    localparam int SI_COL = 5, SI_CRS = 6, SI_VALID = 7, SI_ERR = 8, SI_LANE = 9;
    localparam int SYNC_W = 17;
    typedef enum logic [1:0] {MODE_MII, MODE_RMII, MODE_GMII, MODE_TBI} mode_e;
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;
endpackage

/* core/packet_port_pins.sv */
// One packet port: receive sampling, transmit launch, pin roles, APB regs.
// Assumes pclk far faster than the link clocks, which are sampled as data.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module packet_port_pins #(
    parameter int CLK_HALF = 1
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic [port_pins_pkg::ADDR_W-1:0] paddr,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    output logic                                  irq,
    input  wire logic                             port_rx_clock,
    input  wire logic                             port_reference_clock,
    input  wire logic                             tbi_rx_byte_clock_a,
    input  wire logic                             tbi_rx_byte_clock_b,
    input  wire logic [7:0]                       port_rx_lanes,
    input  wire logic                             port_rx_valid,
    input  wire logic                             port_rx_error,
    input  wire logic                             port_collision_in,
    input  wire logic                             port_carrier_sense_i,
    output logic                                  port_carrier_sense_o,
    output logic                                  port_carrier_sense_oe,
    input  wire logic                             port_tx_clock_i,
    output logic                                  port_tx_clock_o,
    output logic                                  port_tx_clock_oe,
    output logic                                  port_gigabit_tx_clock,
    output logic      [7:0]                       port_tx_lanes,
    output logic                                  port_tx_enable
);
    import port_pins_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [3:0] beat_width(input mode_e m);
        case (m)
            MODE_MII:  beat_width = WIDTH_MII;
            MODE_RMII: beat_width = WIDTH_RMII;
            MODE_GMII: beat_width = WIDTH_GMII;
            default:   beat_width = WIDTH_TBI;
        endcase
    endfunction

    function automatic logic [2:0] beats_per_word(input mode_e m);
        case (m)
            MODE_MII:  beats_per_word = BEATS_MII;
            MODE_RMII: beats_per_word = BEATS_RMII;
            default:   beats_per_word = BEATS_WIDE;
        endcase
    endfunction

    function automatic logic [LANES_W-1:0] lane_mask(input mode_e m);
        case (m)
            MODE_MII:  lane_mask = MASK_MII;
            MODE_RMII: lane_mask = MASK_RMII;
            default:   lane_mask = MASK_WIDE;
        endcase
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_W-1:0] pin_raw, s1_q, s2_q, s3_q, lvl_q, rise;
    assign pin_raw = {port_rx_lanes, port_rx_error, port_rx_valid, port_carrier_sense_i,
                      port_collision_in, port_tx_clock_i, tbi_rx_byte_clock_b,
                      tbi_rx_byte_clock_a, port_reference_clock, port_rx_clock};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q[gi]  <= 1'b0;
                    s2_q[gi]  <= 1'b0;
                    s3_q[gi]  <= 1'b0;
                    lvl_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    // A change counts only once two stages agree
                    if (s2_q[gi] == s3_q[gi]) begin
                        lvl_q[gi] <= s3_q[gi];
                    end
                end
            end
            assign rise[gi] = s2_q[gi] & s3_q[gi] & ~lvl_q[gi];
        end
    endgenerate

    // ==========================================================
    // Registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [IRQ_W-1:0]  irq_st_q, irq_mask_q, ev;
    logic              pready_q, pslverr_q, irq_q;
    logic [31:0]       prdata_q, rd_d;
    logic              map_d;
    logic [CODE_W-1:0] hold_q, rx_word_q;
    logic              hold_full_q, hold_last_q, rx_avail_q;
    mode_e             mode;
    logic              phy_role, half_dx;

    assign mode     = mode_e'(ctrl_q[1:0]);
    assign phy_role = ctrl_q[CTRL_PHY_BIT];
    assign half_dx  = ctrl_q[CTRL_HDX_BIT];

    logic access, done, wr_done, rd_done;
    assign access  = psel & penable;
    assign done    = access & pready_q;
    assign wr_done = done & pwrite;
    assign rd_done = done & ~pwrite;

    logic tx_active_q, rx_active_q;
    logic [31:0] status_w;
    assign status_w = {26'h0, lvl_q[SI_COL], rx_avail_q, hold_full_q, tx_active_q,
                       rx_active_q, lvl_q[SI_CRS]};

    always_comb begin
        rd_d  = 32'h0;
        map_d = 1'b1;
        if (paddr == OFS_CTRL) begin
            rd_d[CTRL_W-1:0] = ctrl_q;
        end else if (paddr == OFS_STATUS) begin
            rd_d = status_w;
        end else if (paddr == OFS_IRQ_STATUS) begin
            rd_d[IRQ_W-1:0] = irq_st_q;
        end else if (paddr == OFS_IRQ_MASK) begin
            rd_d[IRQ_W-1:0] = irq_mask_q;
        end else if (paddr == OFS_TX_DATA) begin
            rd_d[CODE_W-1:0]      = hold_q;
            rd_d[WORD_FLAG_BIT]   = hold_full_q;
        end else if (paddr == OFS_RX_DATA) begin
            rd_d[CODE_W-1:0]      = rx_word_q;
            rd_d[WORD_FLAG_BIT]   = rx_avail_q;
        end else begin
            map_d = 1'b0;
        end
    end

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= access & ~pready_q;
            if (access && !pready_q) begin
                pslverr_q <= ~map_d;
                prdata_q  <= pwrite ? 32'h0 : rd_d;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= CTRL_RESET;
            irq_mask_q <= '0;
        end else if (wr_done && paddr == OFS_CTRL) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
        end else if (wr_done && paddr == OFS_IRQ_MASK) begin
            irq_mask_q <= pwdata[IRQ_W-1:0];
        end
    end

    // Read clears only bits that were returned; new events win
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            if (rd_done && paddr == OFS_IRQ_STATUS) begin
                irq_st_q <= (irq_st_q & ~prdata_q[IRQ_W-1:0]) | ev;
            end else begin
                irq_st_q <= irq_st_q | ev;
            end
            irq_q <= |(irq_st_q & irq_mask_q);
        end
    end

    // ==========================================================
    // Own clock generator for GMII/ten-bit and MII PHY emulation
    logic [7:0] div_q;
    logic       gen_q, gen_rise;
    assign gen_rise = ~gen_q && (div_q == 8'(CLK_HALF - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 8'h0;
            gen_q <= 1'b0;
        end else if (div_q == 8'(CLK_HALF - 1)) begin
            div_q <= 8'h0;
            gen_q <= ~gen_q;
        end else begin
            div_q <= div_q + 8'h1;
        end
    end

    // ==========================================================
    // Transmit
    logic              tx_edge, tx_take, col_hit;
    tx_state_e         tx_st_q;
    logic [CODE_W-1:0] sh_q;
    logic [2:0]        beats_q;
    logic              last_q;
    always_comb begin
        case (mode)
            MODE_MII:  tx_edge = phy_role ? gen_rise : rise[SI_TXCLK];
            MODE_RMII: tx_edge = rise[SI_REF];
            default:   tx_edge = gen_rise;
        endcase
    end
    // Full duplex is the default; collisions ignored there
    assign col_hit = half_dx && !phy_role && mode != MODE_TBI
                     && tx_active_q && lvl_q[SI_COL];
    assign tx_take = tx_edge && beats_q == 3'h0 && hold_full_q
                     && (tx_st_q == TX_IDLE || !last_q) && !col_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q        <= TX_IDLE;
            sh_q           <= '0;
            beats_q        <= 3'h0;
            last_q         <= 1'b0;
            port_tx_lanes  <= 8'h0;
            port_tx_enable <= 1'b0;
            tx_active_q    <= 1'b0;
        end else if (col_hit) begin
            tx_st_q        <= TX_IDLE;
            beats_q        <= 3'h0;
            port_tx_lanes  <= 8'h0;
            port_tx_enable <= 1'b0;
            tx_active_q    <= 1'b0;
        end else if (tx_edge) begin
            case (tx_st_q)
                TX_IDLE: begin
                    if (tx_take) begin
                        port_tx_lanes  <= hold_q[LANES_W-1:0] & lane_mask(mode);
                        // Ten-bit code bit 8 rides on the enable pin
                        port_tx_enable <= (mode == MODE_TBI) ? hold_q[LANES_W] : 1'b1;
                        sh_q           <= hold_q >> beat_width(mode);
                        beats_q        <= beats_per_word(mode) - 3'h1;
                        last_q         <= hold_last_q;
                        tx_st_q        <= TX_SEND;
                        tx_active_q    <= 1'b1;
                    end
                end
                TX_SEND: begin
                    if (beats_q != 3'h0) begin
                        port_tx_lanes <= sh_q[LANES_W-1:0] & lane_mask(mode);
                        sh_q          <= sh_q >> beat_width(mode);
                        beats_q       <= beats_q - 3'h1;
                    end else if (tx_take) begin
                        port_tx_lanes  <= hold_q[LANES_W-1:0] & lane_mask(mode);
                        port_tx_enable <= (mode == MODE_TBI) ? hold_q[LANES_W] : 1'b1;
                        sh_q           <= hold_q >> beat_width(mode);
                        beats_q        <= beats_per_word(mode) - 3'h1;
                        last_q         <= hold_last_q;
                    end else begin
                        // Last beat has had a full period; drop enable now
                        port_tx_lanes  <= 8'h0;
                        port_tx_enable <= 1'b0;
                        tx_st_q        <= TX_IDLE;
                        tx_active_q    <= 1'b0;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // Holding word: writes refused while full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q      <= '0;
            hold_full_q <= 1'b0;
            hold_last_q <= 1'b0;
        end else if (tx_take) begin
            hold_full_q <= 1'b0;
        end else if (wr_done && paddr == OFS_TX_DATA && !hold_full_q) begin
            hold_q      <= pwdata[CODE_W-1:0];
            hold_last_q <= pwdata[WORD_FLAG_BIT];
            hold_full_q <= 1'b1;
        end
    end

    // ==========================================================
    // Receive
    logic              rx_edge, rx_valid_now, rx_word_done;
    logic [CODE_W-1:0] beat_val, acc_q;
    logic [3:0]        pos_q;
    logic [2:0]        cnt_q;
    logic [LANES_W-1:0] lanes_now;
    assign lanes_now = lvl_q[SI_LANE +: LANES_W] & lane_mask(mode);
    always_comb begin
        case (mode)
            MODE_RMII: begin
                rx_edge      = rise[SI_REF];
                rx_valid_now = lvl_q[SI_VALID];
            end
            MODE_TBI: begin
                rx_edge      = rise[SI_BCA] | rise[SI_BCB];
                rx_valid_now = lvl_q[SI_CRS];
            end
            default: begin
                rx_edge      = rise[SI_RXCLK];
                rx_valid_now = lvl_q[SI_VALID];
            end
        endcase
        beat_val = (mode == MODE_TBI) ? {lvl_q[SI_ERR], lvl_q[SI_VALID], lanes_now}
                                      : {2'b00, lanes_now};
    end
    assign rx_word_done = rx_edge && rx_valid_now && cnt_q == beats_per_word(mode) - 3'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q       <= '0;
            pos_q       <= 4'h0;
            cnt_q       <= 3'h0;
            rx_active_q <= 1'b0;
        end else if (rx_edge && rx_valid_now) begin
            rx_active_q <= 1'b1;
            if (rx_word_done) begin
                acc_q <= '0;
                pos_q <= 4'h0;
                cnt_q <= 3'h0;
            end else begin
                acc_q <= acc_q | (beat_val << pos_q);
                pos_q <= pos_q + beat_width(mode);
                cnt_q <= cnt_q + 3'h1;
            end
        end else if (rx_edge) begin
            acc_q       <= '0;
            pos_q       <= 4'h0;
            cnt_q       <= 3'h0;
            rx_active_q <= 1'b0;
        end
    end

    // New word wins over a read clearing the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_word_q  <= '0;
            rx_avail_q <= 1'b0;
        end else if (rx_word_done) begin
            rx_word_q  <= acc_q | (beat_val << pos_q);
            rx_avail_q <= 1'b1;
        end else if (rd_done && paddr == OFS_RX_DATA) begin
            rx_avail_q <= 1'b0;
        end
    end

    always_comb begin
        ev             = '0;
        ev[IRQ_FRAME]  = rx_edge && !rx_valid_now && rx_active_q;
        ev[IRQ_RXERR]  = rx_edge && rx_valid_now && mode != MODE_TBI
                         && lvl_q[SI_ERR];
        ev[IRQ_FALSE]  = rx_edge && !rx_valid_now && mode != MODE_TBI && lvl_q[SI_ERR]
                         && lanes_now == (FALSE_CARRIER & lane_mask(mode));
        ev[IRQ_COL]    = col_hit;
        ev[IRQ_TXDONE] = tx_edge && tx_st_q == TX_SEND && beats_q == 3'h0
                         && !tx_take && last_q;
        ev[IRQ_UNDER]  = tx_edge && tx_st_q == TX_SEND && beats_q == 3'h0
                         && !tx_take && !last_q;
        ev[IRQ_OVER]   = rx_word_done && rx_avail_q
                         && !(rd_done && paddr == OFS_RX_DATA);
    end

    // ==========================================================
    // Pin roles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_carrier_sense_o  <= 1'b0;
            port_carrier_sense_oe <= 1'b0;
            port_tx_clock_o       <= 1'b0;
            port_tx_clock_oe      <= 1'b0;
            port_gigabit_tx_clock <= 1'b0;
        end else begin
            port_carrier_sense_oe <= phy_role;
            // Emulated PHY reports either direction busy; ten-bit shows signal present
            port_carrier_sense_o  <= phy_role && (mode == MODE_TBI
                                     || tx_active_q || rx_active_q);
            port_tx_clock_oe      <= phy_role && mode == MODE_MII;
            port_tx_clock_o       <= phy_role && mode == MODE_MII && gen_q;
            port_gigabit_tx_clock <= (mode == MODE_GMII || mode == MODE_TBI) && gen_q;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;
endmodule // packet_port_pins

/* tb/phy_model.sv */
// Far-end PHY model: link clock, MII receive beats, transmit capture.
// Assumes MII timing; the link clock stands still while run is low.
`timescale 1ns/1ns
module phy_model (
    input  wire logic       run,
    input  wire logic [7:0] tx_lanes,
    input  wire logic       tx_enable,
    output logic            link_clock,
    output logic [7:0]      rx_lanes,
    output logic            rx_valid,
    output logic            rx_error,
    output logic [7:0]      tx_byte
);
    // ====================
    // Clock and lanes
    initial begin
        link_clock = 1'b0;
        {rx_lanes, rx_valid, rx_error} = 10'h0;
        #7;
        forever #160 if (run) link_clock = ~link_clock;
    end
    // Low nibble arrives first
    always @(posedge link_clock) begin
        if (tx_enable) tx_byte <= {tx_lanes[3:0], tx_byte[7:4]};
    end
    // Changes on the falling edge, clear of the sampling edge
    task automatic drive(input logic [7:0] l, input logic v, input logic e);
        @(negedge link_clock);
        rx_lanes = l;
        rx_valid = v;
        rx_error = e;
    endtask
    task automatic send(input logic [7:0] b, input logic e);
        drive({4'h0, b[3:0]}, 1'b1, e);
        drive({4'h0, b[7:4]}, 1'b1, e);
        // Released lanes show the inverse, not the last beat
        drive({4'hf, ~b[7:4]}, 1'b0, 1'b0);
    endtask
endmodule // phy_model

/* tb/pins_properties.sv */
// Concurrent checks on the port pin block, from its top ports only.
// Assumes CTRL changes only by APB writes; bound in at the foot.
`timescale 1ns/1ns
module pins_properties #(
    parameter int CLK_HALF = 1
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        port_carrier_sense_oe,
    input wire logic        port_tx_clock_oe,
    input wire logic        port_gigabit_tx_clock,
    input wire logic [7:0]  port_tx_lanes,
    input wire logic        port_tx_enable
);
    import port_pins_pkg::*;
    localparam int GTX_MAX = 2 * CLK_HALF + 2;
    logic [3:0] ctrl_q;
    logic [1:0] age_q;
    logic       steady;
    assign steady = (age_q == 2'h3);
    // ====================
    // CTRL mirror; outputs judged once it is steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            age_q  <= 2'h0;
        end else if (psel && penable && pready && pwrite && !pslverr && paddr == OFS_CTRL) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
            age_q  <= 2'h0;
        end else if (!steady) begin
            age_q <= age_q + 2'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence one_wait;
        !pready ##1 pready;
    endsequence
    sequence beat_held;
        port_tx_enable [*8];
    endsequence
    apb_wait_a: assert property (psel && penable && !$past(penable) |-> one_wait)
        else $error("pready not after one wait");
    slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    crs_dir_a: assert property (steady |-> port_carrier_sense_oe == ctrl_q[2])
        else $error("carrier sense direction");
    txclk_dir_a: assert property (steady |-> port_tx_clock_oe == (ctrl_q[2:0] == 3'h4))
        else $error("tx clock direction");
    gtx_idle_a: assert property (steady && !ctrl_q[1] |-> !port_gigabit_tx_clock)
        else $error("gigabit clock outside mode");
    gtx_run_a: assert property (steady && ctrl_q[1] |->
        ##[1:GTX_MAX] port_gigabit_tx_clock != $past(port_gigabit_tx_clock))
        else $error("gigabit clock stalled");
    tx_hold_a: assert property ($rose(port_tx_enable) && ctrl_q == 4'h0 |-> beat_held)
        else $error("tx enable short");
    mii_upper_a: assert property (steady && ctrl_q[1:0] == MODE_MII |->
        port_tx_lanes[7:4] == 4'h0) else $error("upper lanes driven");
endmodule // pins_properties
bind packet_port_pins pins_properties #(.CLK_HALF(CLK_HALF)) u_props (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .port_carrier_sense_oe(port_carrier_sense_oe), .port_tx_clock_oe(port_tx_clock_oe),
    .port_gigabit_tx_clock(port_gigabit_tx_clock), .port_tx_lanes(port_tx_lanes),
    .port_tx_enable(port_tx_enable)
);

/* tb/test_multimode_packet_port_pins.sv */
// Bench for the port pin block: APB task, PHY model, MII traffic, modes.
// Assumes the checker binds itself in; link clock period 320 ns.
`timescale 1ns/1ns
module test_multimode_packet_port_pins;
    import port_pins_pkg::*;
    localparam logic [31:0] TXW [2] = '{32'h0001_00a5, 32'h0000_005a};
    localparam logic [31:0] TXI [2] = '{32'h10, 32'h20};
    localparam logic [7:0]  RXB [2] = '{8'h5c, 8'h93};
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, irq, run, cs_in, rerr;
    logic        lclk, rx_valid, rx_error, cs_o, cs_oe, tclk_o, tclk_oe, tx_en;
    logic [7:0]  paddr, rx_lanes, tx_lanes, tx_byte;
    logic [31:0] pwdata, prdata, rdat;
    wire logic   cs_pin = cs_oe ? cs_o : cs_in;
    wire logic   tclk_pin = tclk_oe ? tclk_o : lclk;
    int          err_count = 0;
    int          checks = 0;
    always #20 pclk = ~pclk;
    packet_port_pins #(.CLK_HALF(1)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .port_rx_clock(lclk),
        .port_reference_clock(lclk),
        .tbi_rx_byte_clock_a(1'b0), .tbi_rx_byte_clock_b(1'b0), .port_rx_lanes(rx_lanes),
        .port_rx_valid(rx_valid), .port_rx_error(rx_error),
        .port_collision_in(1'b0),
        .port_carrier_sense_i(cs_pin), .port_carrier_sense_o(cs_o),
        .port_carrier_sense_oe(cs_oe), .port_tx_clock_i(tclk_pin), .port_tx_clock_o(tclk_o),
        .port_tx_clock_oe(tclk_oe), .port_gigabit_tx_clock(), .port_tx_lanes(tx_lanes),
        .port_tx_enable(tx_en)
    );
    phy_model i_phy (
        .run(run), .tx_lanes(tx_lanes), .tx_enable(tx_en), .link_clock(lclk),
        .rx_lanes(rx_lanes), .rx_valid(rx_valid), .rx_error(rx_error), .tx_byte(tx_byte)
    );
    // ====================
    // Tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        check("pready", 1, pready);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        check("irq", 1, irq);
    endtask
    task automatic close_out();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #3000000;
        check("watchdog", 0, 1);
        close_out();
    end
    // ====================
    // Tests
    initial begin
        {presetn, psel, penable, pwrite, run, cs_in, paddr, pwdata} = 46'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_CTRL, 0);
        check("ctrl reset", {28'h0, CTRL_RESET}, rdat);
        apb(0, 8'h20, 0);
        check("unmapped err", 1, rerr);
        check("unmapped data", 0, rdat);
        apb(1, OFS_IRQ_MASK, 32'h7f);
        run <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            apb(1, OFS_TX_DATA, TXW[i]);
            wait_irq();
            apb(0, OFS_IRQ_STATUS, 0);
            check("tx event", TXI[i], rdat);
            check("tx byte", TXW[i][7:0], tx_byte);
            check("tx enable", 0, tx_en);
        end
        // Frame end only, so an early error cannot end the wait
        apb(1, OFS_IRQ_MASK, 32'h01);
        for (int i = 0; i < 2; i++) begin
            i_phy.send(RXB[i], i[0]);
            wait_irq();
            apb(0, OFS_RX_DATA, 0);
            check("rx word", {16'h1, 8'h0, RXB[i]}, rdat);
            apb(0, OFS_IRQ_STATUS, 0);
            check("rx event", {30'h0, i[0], 1'b1}, rdat);
        end
        apb(1, OFS_IRQ_MASK, 32'h0);
        i_phy.drive(FALSE_CARRIER, 1'b0, 1'b1);
        repeat (2) i_phy.drive(~FALSE_CARRIER, 1'b0, 1'b0);
        check("irq masked", 0, irq);
        apb(0, OFS_IRQ_STATUS, 0);
        check("false carrier", 32'h4, rdat);
        apb(0, OFS_IRQ_STATUS, 0);
        check("status cleared", 0, rdat);
        run <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cs_in <= i[1];
            apb(1, OFS_CTRL, i);
            apb(0, OFS_CTRL, 0);
            check("ctrl", i, rdat);
            check("crs drive", i[2], cs_oe);
            check("txclk drive", i == 4, tclk_oe);
            apb(0, OFS_STATUS, 0);
            if (!i[2]) check("carrier in", i[1], rdat[0]);
        end
        close_out();
    end
endmodule // test_multimode_packet_port_pins
